// *** rtl/area_decode_map.svh ***
// Purpose: Constants for the physical area decoder
// Assumes: 32-bit physical addresses, eight 64 Mbyte areas
// Notes:   Included by the decoder; the package holds only types
`ifndef AREA_DECODE_MAP_SVH
`define AREA_DECODE_MAP_SVH

`define AREA_FIELD_MSB      28
`define AREA_FIELD_LSB      26
`define AREA_CODE_0         3'h0
`define AREA_CODE_1         3'h1
`define AREA_CODE_2         3'h2
`define AREA_CODE_3         3'h3
`define AREA_CODE_4         3'h4
`define AREA_CODE_5         3'h5
`define AREA_CODE_6         3'h6
`define AREA_CODE_7         3'h7
`define SHADOW_STRIDE       32'h20000000
`define AREA5_BASE          32'h14000000
`define AREA6_BASE          32'h18000000
`define WIDTH_RESET         2'h0
`define SELECT_IDLE         7'h7F

`endif

// *** rtl/area_decode_pkg.sv ***
// Purpose: Types for the physical area decoder
// Assumes: Constants live in area_decode_map.svh
// Notes:   Width codes follow the strap encoding
package area_decode_pkg;

    typedef enum logic [1:0]
    {
        WIDTH_RESERVED = 2'b00,
        WIDTH_BYTE     = 2'b01,
        WIDTH_WORD     = 2'b10,
        WIDTH_LONG     = 2'b11
    } bus_width_t;

    typedef struct packed
    {
        logic        valid;
        logic [31:0] address;
        logic [3:0]  byteEnable;
    } access_t;

    typedef struct packed
    {
        bus_width_t width6;
        bus_width_t width5;
        bus_width_t width4;
        bus_width_t width3;
        bus_width_t width2;
    } width_control_t;

endpackage : area_decode_pkg

// *** rtl/physical_area_decoder.sv ***
// Purpose: Decode external bus accesses into area selects and bus widths
// Assumes: Access request comes from logic on clk_sys; straps are pins
// Notes:   Outputs are registered, one cycle after the request
//
// Contract
// [RQ1] The low 29 bits of the physical address are decoded into eight areas.
// [RQ2] Areas 0 and 2 to 6 are selected by address bits 28 to 26, codes 000 to 110.
// [RQ3] Bits 31 to 29 are ignored, so each area repeats every 0x20000000.
// [RQ4] Only the accessed area's active-low select asserts, areas 0 and 2 to 6 each own one.
// [RQ5] A PCMCIA area 5 or 6 also asserts its card enable for the upper byte lanes accessed.
// [RQ6] Areas 5 and 6 at 0x14000000 and 0x18000000 each serve one PCMCIA interface.
// [RQ7] Area 0 width is fixed from two mode straps at power-on reset.
// [RQ8] The board never straps the reserved width combination.
// [RQ9] Straps 00 reserved, 01 byte, 10 word, 11 longword.
// [RQ10] Areas 2 to 6 take their width from the bus width control setting.
// [RQ11] Software uses only 16 or 32 bits on synchronous DRAM areas.
// [RQ12] Software uses only 8 or 16 bits on PCMCIA areas.
// [RQ13] Software sets equal widths on areas 2 and 3 when both hold synchronous DRAM.
// [RQ14] Software avoids longword widths while the port function is used.
// [RQ15] Masters never access area 7 or its shadows.
// [RQ16] Untranslated area 1 register accesses use the uncached untranslated region.
// [RQ17] An area 1 access is handled on chip and asserts no external select.
`include "area_decode_map.svh"
`timescale 1ns/1ps
`default_nettype none

module physical_area_decoder
(
    // Clock and reset
    input  wire logic                            clk_sys,
    input  wire logic                            resetn,
    // Mode straps
    input  wire logic                            width_strap_low,
    input  wire logic                            width_strap_high,
    // Configuration
    input  wire area_decode_pkg::width_control_t bus_width_control,
    input  wire logic                            area5Pcmcia,
    input  wire logic                            area6Pcmcia,
    // Access request
    input  wire area_decode_pkg::access_t        access,
    // Selects
    output logic                                 area0_select_n,
    output logic [4:0]                           area_select_n,
    output logic                                 card_enable_hi_area5_n,
    output logic                                 card_enable_hi_area6_n,
    // Status
    output area_decode_pkg::bus_width_t          area0Width,
    output area_decode_pkg::bus_width_t          accessWidth,
    output logic                                 internalAccess,
    output logic                                 reservedAccess
);

    // ************************************************************
    // Strap capture
    // ************************************************************
    logic [1:0] strapMeta;
    logic [1:0] strapSync;
    logic       strapTaken;

    always_ff @(posedge clk_sys or negedge resetn)
    begin
        if (!resetn)
        begin
            strapMeta <= 2'h0;
            strapSync <= 2'h0;
        end
        else
        begin
            strapMeta <= {width_strap_high, width_strap_low};
            strapSync <= strapMeta;
        end
    end

    // Caught once, after the synchroniser has settled past release
    logic [1:0] settle;

    always_ff @(posedge clk_sys or negedge resetn)
    begin
        if (!resetn)
        begin
            settle     <= 2'h0;
            strapTaken <= 1'b0;
            area0Width <= area_decode_pkg::bus_width_t'(`WIDTH_RESET);
        end
        else if (!strapTaken)
        begin
            settle <= settle + 2'h1;
            if (settle == 2'h2)
            begin
                strapTaken <= 1'b1;
                area0Width <= area_decode_pkg::bus_width_t'(strapSync); // [RQ7] [RQ9]
            end
        end
    end

    // ************************************************************
    // Area decode
    // ************************************************************
    logic [2:0] areaCode;
    logic [6:0] next_select;
    logic       next_ce5;
    logic       next_ce6;
    logic       upperLanes;
    area_decode_pkg::bus_width_t next_width;

    // Top three bits never enter the decode
    assign areaCode   = access.address[`AREA_FIELD_MSB:`AREA_FIELD_LSB]; // [RQ1] [RQ2] [RQ3]
    assign upperLanes = |access.byteEnable[3:1];

    always_comb
    begin
        next_select = `SELECT_IDLE;
        next_ce5    = 1'b1;
        next_ce6    = 1'b1;
        next_width  = area_decode_pkg::WIDTH_RESERVED;
        if (access.valid && strapTaken)
        begin
            case (areaCode)
                `AREA_CODE_0:
                begin
                    next_select[0] = 1'b0; // [RQ4]
                    next_width     = area0Width;
                end
                `AREA_CODE_2:
                begin
                    next_select[2] = 1'b0;
                    next_width     = bus_width_control.width2; // [RQ10]
                end
                `AREA_CODE_3:
                begin
                    next_select[3] = 1'b0;
                    next_width     = bus_width_control.width3;
                end
                `AREA_CODE_4:
                begin
                    next_select[4] = 1'b0;
                    next_width     = bus_width_control.width4;
                end
                `AREA_CODE_5:
                begin
                    next_select[5] = 1'b0;
                    next_ce5       = !(area5Pcmcia && upperLanes); // [RQ5] [RQ6]
                    next_width     = bus_width_control.width5;
                end
                `AREA_CODE_6:
                begin
                    next_select[6] = 1'b0;
                    next_ce6       = !(area6Pcmcia && upperLanes); // [RQ5] [RQ6]
                    next_width     = bus_width_control.width6;
                end
                default:
                begin
                    // Area 1 stays on chip, area 7 drives nothing
                    next_select = `SELECT_IDLE; // [RQ17]
                end
            endcase
        end
    end

    // ************************************************************
    // Output registers
    // ************************************************************
    always_ff @(posedge clk_sys or negedge resetn)
    begin
        if (!resetn)
        begin
            area0_select_n         <= 1'b1;
            area_select_n          <= 5'h1F;
            card_enable_hi_area5_n <= 1'b1;
            card_enable_hi_area6_n <= 1'b1;
            accessWidth            <= area_decode_pkg::bus_width_t'(`WIDTH_RESET);
        end
        else
        begin
            area0_select_n         <= next_select[0];
            area_select_n          <= next_select[6:2]; // [RQ4]
            card_enable_hi_area5_n <= next_ce5;
            card_enable_hi_area6_n <= next_ce6;
            accessWidth            <= next_width;
        end
    end

    always_ff @(posedge clk_sys or negedge resetn)
    begin
        if (!resetn)
        begin
            internalAccess <= 1'b0;
            reservedAccess <= 1'b0;
        end
        else
        begin
            internalAccess <= access.valid && strapTaken && areaCode == `AREA_CODE_1; // [RQ17]
            reservedAccess <= access.valid && strapTaken && areaCode == `AREA_CODE_7; // [RQ15]
        end
    end

    // ************************************************************
    // Assertions
    // ************************************************************
    a_one_select_only: assert property (@(posedge clk_sys) disable iff (!resetn) // [RQ4]
        $countones({~area0_select_n, ~area_select_n}) <= 1)
        else $error("More than one area select active");

    a_area0_follows: assert property (@(posedge clk_sys) disable iff (!resetn) // [RQ2]
        (access.valid && strapTaken && areaCode == `AREA_CODE_0) |=> !area0_select_n)
        else $error("Area 0 select missing");

    a_area6_follows: assert property (@(posedge clk_sys) disable iff (!resetn) // [RQ3]
        (access.valid && strapTaken && access.address[28:26] == 3'h6) |=> !area_select_n[4])
        else $error("Area 6 select missing in shadow");

    a_area1_silent: assert property (@(posedge clk_sys) disable iff (!resetn) // [RQ17]
        internalAccess |-> (area0_select_n && area_select_n == 5'h1F))
        else $error("External select on area 1");

    a_card5_needs_cs: assert property (@(posedge clk_sys) disable iff (!resetn) // [RQ5]
        !card_enable_hi_area5_n |-> !area_select_n[3])
        else $error("Card enable 5 without select");

    a_card6_pcmcia: assert property (@(posedge clk_sys) disable iff (!resetn) // [RQ6]
        (access.valid && strapTaken && areaCode == `AREA_CODE_6 && area6Pcmcia
         && access.byteEnable[1]) |=> !card_enable_hi_area6_n)
        else $error("Card enable 6 missing");

    a_strap_held: assert property (@(posedge clk_sys) disable iff (!resetn) // [RQ7]
        strapTaken |=> $stable(area0Width))
        else $error("Area 0 width changed after capture");

    a_width_area2: assert property (@(posedge clk_sys) disable iff (!resetn) // [RQ10]
        (access.valid && strapTaken && areaCode == `AREA_CODE_2)
        |=> accessWidth == $past(bus_width_control.width2))
        else $error("Area 2 width wrong");

    a_strap_window: assert property (@(posedge clk_sys) disable iff (!resetn) // [RQ7]
        $rose(resetn) |-> ##[1:4] strapTaken)
        else $error("Strap not captured in time");

endmodule : physical_area_decoder

`default_nettype wire

// *** bench/area_target_model.sv ***
// Purpose: Far-side memories and cards seen by the decoder
// Assumes: Selects and card enables are active low
// Notes:   Reports how many targets and cards answer
`timescale 1ns/1ps
`default_nettype none

module area_target_model
(
    // Selects
    input  wire logic       area0_select_n,
    input  wire logic [4:0] area_select_n,
    input  wire logic       card_enable_hi_area5_n,
    input  wire logic       card_enable_hi_area6_n,
    // Observation
    output logic [2:0]      selectCount,
    output logic [1:0]      cardActive
);
    // Two selects at once would mean a bus fight
    assign selectCount = 3'($countones({~area0_select_n, ~area_select_n}));
    // A card answers only with its area select and its card enable
    assign cardActive = {~area_select_n[4] & ~card_enable_hi_area6_n,
                         ~area_select_n[3] & ~card_enable_hi_area5_n};
endmodule : area_target_model
`default_nettype wire

// *** bench/physical_area_decoder_tb.sv ***
// Purpose: Self-checking bench for the area decoder
// Assumes: Outputs answer one cycle after the request
// Notes:   Notes go in a queue, a monitor pops them
`timescale 1ns/1ps
`default_nettype none

module physical_area_decoder_tb;
    logic clk_sys, resetn, width_strap_low, width_strap_high, area5Pcmcia, area6Pcmcia;
    area_decode_pkg::width_control_t bus_width_control;
    area_decode_pkg::access_t access;
    area_decode_pkg::bus_width_t area0Width, accessWidth;
    logic area0_select_n, card_enable_hi_area5_n, card_enable_hi_area6_n;
    logic internalAccess, reservedAccess;
    logic [4:0] area_select_n;
    logic [2:0] selectCount;
    logic [1:0] cardActive, strapCode;
    logic [9:0] widthBits;
    logic [11:0] noteQ[$];
    logic [11:0] e;
    int n_fail, tests_run;
    wire logic [11:0] seen = {area0_select_n, area_select_n, card_enable_hi_area5_n,
                              card_enable_hi_area6_n, accessWidth, internalAccess, reservedAccess};

    physical_area_decoder physical_area_decoder_inst (.clk_sys(clk_sys), .resetn(resetn),
        .width_strap_low(width_strap_low), .width_strap_high(width_strap_high),
        .bus_width_control(bus_width_control), .area5Pcmcia(area5Pcmcia),
        .area6Pcmcia(area6Pcmcia), .access(access), .area0_select_n(area0_select_n),
        .area_select_n(area_select_n), .card_enable_hi_area5_n(card_enable_hi_area5_n),
        .card_enable_hi_area6_n(card_enable_hi_area6_n), .area0Width(area0Width),
        .accessWidth(accessWidth), .internalAccess(internalAccess),
        .reservedAccess(reservedAccess));
    area_target_model area_target_model_inst (.area0_select_n(area0_select_n),
        .area_select_n(area_select_n), .card_enable_hi_area5_n(card_enable_hi_area5_n),
        .card_enable_hi_area6_n(card_enable_hi_area6_n), .selectCount(selectCount),
        .cardActive(cardActive));

    task automatic check(input logic [11:0] got, input logic [11:0] exp);
        tests_run++;
        if (got !== exp)
        begin
            n_fail++;
            $display("[ERR] t=%0t seen=%h expected=%h", $time, got, exp);
        end
    endtask : check

    task automatic close_out;
        if (noteQ.size() != 0) n_fail++;
        $display("comparisons=%0d mismatches=%0d", tests_run, n_fail);
        if (n_fail == 0 && tests_run > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask : close_out

    function automatic logic [11:0] expect_of(input logic [31:0] a, input logic [3:0] be);
        logic [2:0] c;
        logic [4:0] sel;
        logic [1:0] w;
        c = a[28:26];
        sel = 5'h1F;
        w = (c == 3'h0) ? strapCode : 2'h0;
        if (c >= 3'h2 && c <= 3'h6)
        begin
            sel[c - 3'h2] = 1'b0;
            w = widthBits[2 * (c - 3'h2) +: 2];
        end
        return {c != 3'h0, sel, !(c == 3'h5 && area5Pcmcia && |be[3:1]),
                !(c == 3'h6 && area6Pcmcia && |be[3:1]), w, c == 3'h1, c == 3'h7};
    endfunction : expect_of

    task automatic send(input logic [31:0] a, input logic [3:0] be);
        @(negedge clk_sys);
        access = '{valid: 1'b1, address: a, byteEnable: be};
        noteQ.push_back(expect_of(a, be));
    endtask : send

    task automatic do_reset(input logic [1:0] s);
        // Let the monitor see the last answer before the outputs are cleared
        @(negedge clk_sys);
        resetn = 1'b0;
        {width_strap_high, width_strap_low} = s;
        strapCode = s;
        repeat (16) @(negedge clk_sys);
        check(seen, 12'hFF0);
        resetn = 1'b1;
        access.valid = 1'b1;
        repeat (2) @(negedge clk_sys);
        access.valid = 1'b0;
        repeat (2) @(negedge clk_sys);
        check({10'h0, area0Width}, {10'h0, s});
    endtask : do_reset

    // ******** Monitor ********
    always @(negedge clk_sys)
        if (resetn === 1'b1 && seen !== 12'hFF0)
        begin
            e = (noteQ.size() != 0) ? noteQ.pop_front() : 12'hFF0;
            check(seen, e);
            check({7'h0, selectCount, cardActive}, {7'h0, 3'($countones(~e[11:6])),
                  ~e[4] & ~e[10], ~e[5] & ~e[9]});
        end

    initial
    begin
        clk_sys = 1'b0;
        forever #12.5 clk_sys = ~clk_sys;
    end

    initial
    begin
        repeat (20000) @(posedge clk_sys);
        n_fail++;
        close_out();
    end

    // ******** Stimulus ********
    initial
    begin
        resetn = 1'b0;
        access = '0;
        widthBits = 10'h155;
        bus_width_control = widthBits;
        {area5Pcmcia, area6Pcmcia} = 2'h0;
        void'($urandom(32'h2074));
        for (int s = 1; s < 4; s++)
        begin
            do_reset(2'(s));
            {width_strap_high, width_strap_low} = (s == 1) ? 2'h2 : 2'h1;
            send({3'(s), 29'h0}, 4'hF);
            @(negedge clk_sys);
            access.valid = 1'b0;
            check({10'h0, area0Width}, {10'h0, 2'(s)});
        end
        for (int b = 0; b < 8; b++)
        begin
            @(negedge clk_sys);
            access.valid = 1'b0;
            {area5Pcmcia, area6Pcmcia} = 2'($urandom);
            for (int i = 0; i < 5; i++)
                widthBits[2 * i +: 2] = 2'($urandom_range(1, ((i == 3 && area5Pcmcia)
                    || (i == 4 && area6Pcmcia)) ? 2 : 3));
            bus_width_control = widthBits;
            send(32'h38000000, 4'hF);
            send(32'h18000000, 4'h1);
            send(32'hA4000000, 4'hF);
            // Area 7 left out: no master may touch it or its shadows
            for (int i = 0; i < 12; i++)
                send({3'($urandom), 3'($urandom_range(0, 6)), 26'($urandom)}, 4'($urandom));
        end
        @(negedge clk_sys);
        access.valid = 1'b0;
        repeat (3) @(negedge clk_sys);
        close_out();
    end
endmodule : physical_area_decoder_tb
`default_nettype wire
